// file: src/stc_top.sv
// Notes on behaviour
// - counter, both compare values and capture value are 16 bits wide.
// - both control registers are 8 bits, plain read and write access.
// - each timer event sets a flag, each flag gated by its own mask.
// - tick comes from prescaler or external pin, chosen by source select.
// - source select zero gives no tick; counter holds its value.
// - both active compare values compared with counter every cycle.
// - a compare match sets its match flag, unmasked it requests service.
// - compare results drive a pwm or frequency wave on each output.
// - qualifying pin or comparator edge copies counter into capture value.
// - optional digital noise filter sits before capture edge detection.
// - top comes from compare value a, capture value or a fixed value.
// - channel a gives no pwm output when it supplies top.
// - compare value a as pwm top is double buffered.
// - bottom indication asserts when counter value is zero.
// - fixed maximum 0xFF is selectable as top.
// - counter high byte location reaches the shared high-byte latch.
// - low read loads latch from high; low write moves latch into high.
// - each tick clears, increments or decrements the counter by mode.
// - counter readable and writable whether or not ticks run.
// - cpu write to counter beats clear or count in same cycle.
// - 4-bit waveform mode field split over both control registers.
// - overflow flag point depends on mode; unmasked it requests service.
// - compare flag sets on the tick after the match.
// - flags clear on service acknowledge or when written with one.
// - capture low read loads latch; high read returns latch.
// - filter passes a change only after four agreeing samples.
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"
module stc_top #(
   parameter int FILTER_DEPTH = `STC_FILT_DEPTH
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // pins
   input wire logic i_ext_count_pin,
   input wire logic i_capture_pin,
   input wire logic i_comparator_output,
   output logic o_compare_out_a,
   output logic o_compare_out_b,
   // service requests
   input wire logic [3:0] i_irq_ack,
   output logic [3:0] o_irq_req
);
   logic [7:0] control_reg_a;
   logic [7:0] control_reg_b;
   logic [7:0] aux;
   logic [3:0] irq_mask_reg;
   logic [3:0] irq_flag_reg;
   logic [7:0] temp;
   logic [15:0] count_value;
   logic [15:0] cmpa_buf;
   logic [15:0] cmpb_buf;
   logic [15:0] compare_value_a;
   logic [15:0] compare_value_b;
   logic [15:0] capture_value;
   logic [`STC_PRE_W-1:0] pre;
   stc_pkg::stc_dir_t dir;
   logic ext_prev;
   logic [2:0] pins_sync;
   logic cap_edge;

   if (FILTER_DEPTH != `STC_FILT_DEPTH) begin
      $error("stc_top: FILTER_DEPTH must be 4");
   end

   // pins pass two flops before any use
   stc_sync #(
      .W(3)
   ) u_sync (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_async({i_comparator_output, i_capture_pin, i_ext_count_pin}),
      .o_sync(pins_sync)
   );

   // bus phases: access waits one cycle, completes with pready high
   wire acc = i_psel & i_penable & ~o_pready;
   wire done = i_psel & i_penable & o_pready;
   wire wr = done & i_pwrite;
   wire rd = acc & ~i_pwrite;
   wire [7:0] wb = i_pwdata[7:0];
   wire a_ctla = i_paddr == `STC_ADDR_CTRL_A;
   wire a_ctlb = i_paddr == `STC_ADDR_CTRL_B;
   wire a_cntl = i_paddr == `STC_ADDR_CNT_LO;
   wire a_cnth = i_paddr == `STC_ADDR_CNT_HI;
   wire a_cmpal = i_paddr == `STC_ADDR_CMPA_LO;
   wire a_cmpah = i_paddr == `STC_ADDR_CMPA_HI;
   wire a_cmpbl = i_paddr == `STC_ADDR_CMPB_LO;
   wire a_cmpbh = i_paddr == `STC_ADDR_CMPB_HI;
   wire a_capl = i_paddr == `STC_ADDR_CAP_LO;
   wire a_caph = i_paddr == `STC_ADDR_CAP_HI;
   wire a_flag = i_paddr == `STC_ADDR_FLAGS;
   wire a_mask = i_paddr == `STC_ADDR_MASK;
   wire a_aux = i_paddr == `STC_ADDR_AUX;
   wire mapped = a_ctla | a_ctlb | a_cntl | a_cnth | a_cmpal | a_cmpah |
      a_cmpbl | a_cmpbh | a_capl | a_caph | a_flag | a_mask | a_aux;
   wire any_hi = a_cnth | a_cmpah | a_cmpbh | a_caph;

   // mode decode
   wire [3:0] waveform_mode_field = {
      control_reg_b[`STC_WGM_B_HI:`STC_WGM_B_LO],
      control_reg_a[`STC_WGM_A_HI:`STC_WGM_A_LO]};
   wire [2:0] tick_source_select = control_reg_b[`STC_CS_HI:`STC_CS_LO];
   wire [1:0] com_a = control_reg_a[`STC_COMA_HI:`STC_COMA_LO];
   wire [1:0] com_b = control_reg_a[`STC_COMB_HI:`STC_COMB_LO];
   stc_pkg::stc_top_src_t top_src;
   stc_pkg::stc_slope_t slope;

   always_comb begin
      top_src = stc_pkg::TOP_FIXED;
      slope = stc_pkg::SLOPE_NONE;
      case (waveform_mode_field)
         4'h1, 4'h2, 4'h3: slope = stc_pkg::SLOPE_PHASE;
         4'h4: top_src = stc_pkg::TOP_CMP_A;
         4'h5, 4'h6, 4'h7: slope = stc_pkg::SLOPE_FAST;
         4'h8, 4'hA: begin
            top_src = stc_pkg::TOP_CAP;
            slope = stc_pkg::SLOPE_PHASE;
         end
         4'h9, 4'hB: begin
            top_src = stc_pkg::TOP_CMP_A;
            slope = stc_pkg::SLOPE_PHASE;
         end
         4'hC: top_src = stc_pkg::TOP_CAP;
         4'hE: begin
            top_src = stc_pkg::TOP_CAP;
            slope = stc_pkg::SLOPE_FAST;
         end
         4'hF: begin
            top_src = stc_pkg::TOP_CMP_A;
            slope = stc_pkg::SLOPE_FAST;
         end
         default: begin
            top_src = stc_pkg::TOP_FIXED;
            slope = stc_pkg::SLOPE_NONE;
         end
      endcase
   end

   wire pwm = slope != stc_pkg::SLOPE_NONE;
   wire phase = slope == stc_pkg::SLOPE_PHASE;
   wire [15:0] fixed_top = (waveform_mode_field[1:0] == 2'h1) ? `STC_TOP_MAX :
      (waveform_mode_field[1:0] == 2'h2) ? `STC_TOP_9B :
      (waveform_mode_field[1:0] == 2'h3) ? `STC_TOP_10B :
      `STC_TOP_FULL;
   wire [15:0] top = (top_src == stc_pkg::TOP_CMP_A) ? compare_value_a :
      (top_src == stc_pkg::TOP_CAP) ? capture_value : fixed_top;
   wire at_top = count_value == top;
   wire at_bottom = count_value == `STC_RST_WORD;

   // tick source
   wire ext_s = pins_sync[0];
   wire ext_rise = ext_s & ~ext_prev;
   wire ext_fall = ~ext_s & ext_prev;
   wire [`STC_PRE_W-1:0] pre_mask =
      (tick_source_select == 3'h2) ? `STC_PRE_M8 :
      (tick_source_select == 3'h3) ? `STC_PRE_M64 :
      (tick_source_select == 3'h4) ? `STC_PRE_M256 :
      (tick_source_select == 3'h5) ? `STC_PRE_M1024 : `STC_PRE_M1;
   wire pre_hit = (pre & pre_mask) == `STC_PRE_M1;
   wire timer_tick = (tick_source_select == 3'h0) ? 1'b0 :
      (tick_source_select == 3'h6) ? ext_fall :
      (tick_source_select == 3'h7) ? ext_rise : pre_hit;

   // counter step
   wire going_down = phase & (((dir == stc_pkg::DIR_UP) & at_top) |
      ((dir == stc_pkg::DIR_DOWN) & ~at_bottom));
   wire [15:0] cnt_step = going_down ? count_value - 16'h0001 :
      (~phase & at_top) ? `STC_RST_WORD :
      count_value + 16'h0001;
   wire cnt_wr = wr & a_cntl;
   wire [15:0] next_count = cnt_wr ? {temp, wb} :
      timer_tick ? cnt_step : count_value;
   stc_pkg::stc_dir_t next_dir;
   assign next_dir = going_down ? stc_pkg::DIR_DOWN : stc_pkg::DIR_UP;

   // compare and buffer update
   wire match_a = count_value == compare_value_a;
   wire match_b = count_value == compare_value_b;
   wire buf_load = ~pwm | (timer_tick & at_top);
   wire ovf_evt = timer_tick & ((slope == stc_pkg::SLOPE_NONE) ?
      (count_value == `STC_TOP_FULL) :
      phase ? ((dir == stc_pkg::DIR_DOWN) & at_bottom) : at_top);

   // capture
   wire cap_allowed = top_src != stc_pkg::TOP_CAP;
   wire cap_src = aux[`STC_CAPSRC_BIT] ? pins_sync[2] : pins_sync[1];
   wire cap_evt = cap_edge & cap_allowed;

   stc_filter #(
      .DEPTH(FILTER_DEPTH)
   ) u_filter (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_enable(control_reg_b[`STC_FILT_BIT]),
      .i_rising(control_reg_b[`STC_EDGE_BIT]),
      .i_level(cap_src),
      .o_edge(cap_edge)
   );

   // flags: hardware set wins over clear
   wire [3:0] flag_set = {cap_evt, timer_tick & match_b,
      timer_tick & match_a, ovf_evt};
   wire [3:0] flag_clr = (wr & a_flag ? wb[3:0] : 4'h0) | i_irq_ack;
   wire [3:0] next_flags = (irq_flag_reg & ~flag_clr) | flag_set;

   // shared high-byte latch
   wire [7:0] next_temp = (wr & any_hi) ? wb :
      (rd & a_cntl) ? count_value[15:8] :
      (rd & a_capl) ? capture_value[15:8] : temp;

   // read mux
   wire [7:0] rd_byte = a_ctla ? control_reg_a :
      a_ctlb ? control_reg_b :
      a_cntl ? count_value[7:0] :
      a_cmpal ? cmpa_buf[7:0] :
      a_cmpah ? cmpa_buf[15:8] :
      a_cmpbl ? cmpb_buf[7:0] :
      a_cmpbh ? cmpb_buf[15:8] :
      a_capl ? capture_value[7:0] :
      (a_cnth | a_caph) ? temp :
      a_flag ? {4'h0, irq_flag_reg} :
      a_mask ? {4'h0, irq_mask_reg} :
      a_aux ? aux : 8'h00;

   // waveform next value per channel
   function automatic logic wave(input logic cur, input logic [1:0] com,
         input logic m, input logic wrap, input logic up,
         input stc_pkg::stc_slope_t sl);
      logic v;
      v = cur;
      case (sl)
         stc_pkg::SLOPE_FAST: begin
            if (m) v = com[0];
            else if (wrap) v = ~com[0];
         end
         stc_pkg::SLOPE_PHASE: begin
            if (m) v = up ? com[0] : ~com[0];
         end
         default: begin
            if (m) v = (com == 2'h1) ? ~cur : com[0];
         end
      endcase
      if (com == 2'h0) v = 1'b0;
      return v;
   endfunction

   wire wrap = timer_tick & at_top;
   wire dir_up = dir == stc_pkg::DIR_UP;
   wire a_is_top = pwm & (top_src == stc_pkg::TOP_CMP_A);
   wire next_oca = a_is_top ? 1'b0 : wave(o_compare_out_a, com_a,
      timer_tick & match_a, wrap, dir_up, slope);
   wire next_ocb = wave(o_compare_out_b, com_b, timer_tick & match_b,
      wrap, dir_up, slope);

   // bus registers
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= 32'h00000000;
      end else begin
         o_pready <= acc;
         o_pslverr <= acc & ~mapped;
         if (rd) o_prdata <= {24'h000000, rd_byte};
      end
   end

   // control registers, plain access
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         control_reg_a <= `STC_RST_BYTE;
         control_reg_b <= `STC_RST_BYTE;
         aux <= `STC_RST_BYTE;
         irq_mask_reg <= 4'h0;
      end else begin
         if (wr & a_ctla) control_reg_a <= wb;
         if (wr & a_ctlb) control_reg_b <= wb;
         if (wr & a_aux) aux <= wb;
         if (wr & a_mask) irq_mask_reg <= wb[3:0];
      end
   end

   // 16-bit values, latch and counter
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         temp <= `STC_RST_BYTE;
         count_value <= `STC_RST_WORD;
         dir <= stc_pkg::DIR_UP;
         pre <= '0;
         ext_prev <= 1'b0;
      end else begin
         temp <= next_temp;
         count_value <= next_count;
         if (timer_tick & ~cnt_wr) dir <= next_dir;
         pre <= pre + `STC_PRE_W'(1);
         ext_prev <= ext_s;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cmpa_buf <= `STC_RST_WORD;
         cmpb_buf <= `STC_RST_WORD;
         compare_value_a <= `STC_RST_WORD;
         compare_value_b <= `STC_RST_WORD;
      end else begin
         if (wr & a_cmpal) cmpa_buf <= {temp, wb};
         if (wr & a_cmpbl) cmpb_buf <= {temp, wb};
         if (buf_load) compare_value_a <= cmpa_buf;
         if (buf_load) compare_value_b <= cmpb_buf;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         capture_value <= `STC_RST_WORD;
      end else if (cap_evt) begin
         capture_value <= count_value;
      end else if (wr & a_capl & ~cap_allowed) begin
         capture_value <= {temp, wb};
      end
   end

   // flags, requests and wave outputs
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         irq_flag_reg <= 4'h0;
         o_irq_req <= 4'h0;
         o_compare_out_a <= 1'b0;
         o_compare_out_b <= 1'b0;
      end else begin
         irq_flag_reg <= next_flags;
         o_irq_req <= next_flags & irq_mask_reg;
         o_compare_out_a <= next_oca;
         o_compare_out_b <= next_ocb;
      end
   end
endmodule
`default_nettype wire

// file: src/stc_map.svh
`ifndef STC_MAP_SVH
`define STC_MAP_SVH

// register byte offsets
`define STC_ADDR_CTRL_A 8'h00
`define STC_ADDR_CTRL_B 8'h04
`define STC_ADDR_CNT_LO 8'h08
`define STC_ADDR_CNT_HI 8'h0C
`define STC_ADDR_CMPA_LO 8'h10
`define STC_ADDR_CMPA_HI 8'h14
`define STC_ADDR_CMPB_LO 8'h18
`define STC_ADDR_CMPB_HI 8'h1C
`define STC_ADDR_CAP_LO 8'h20
`define STC_ADDR_CAP_HI 8'h24
`define STC_ADDR_FLAGS 8'h28
`define STC_ADDR_MASK 8'h2C
`define STC_ADDR_AUX 8'h30

// control_reg_a fields
`define STC_COMA_HI 7
`define STC_COMA_LO 6
`define STC_COMB_HI 5
`define STC_COMB_LO 4
`define STC_WGM_A_HI 1
`define STC_WGM_A_LO 0
// control_reg_b fields
`define STC_FILT_BIT 7
`define STC_EDGE_BIT 6
`define STC_WGM_B_HI 4
`define STC_WGM_B_LO 3
`define STC_CS_HI 2
`define STC_CS_LO 0
// aux register: capture source select
`define STC_CAPSRC_BIT 0

// flag and mask bit positions
`define STC_FLAG_OVF 0
`define STC_FLAG_MA 1
`define STC_FLAG_MB 2
`define STC_FLAG_CAP 3
`define STC_FLAG_W 4

// reset values
`define STC_RST_BYTE 8'h00
`define STC_RST_WORD 16'h0000

// fixed tops
`define STC_TOP_MAX 16'h00FF
`define STC_TOP_9B 16'h01FF
`define STC_TOP_10B 16'h03FF
`define STC_TOP_FULL 16'hFFFF

// prescaler taps, tick when masked bits are zero
`define STC_PRE_W 10
`define STC_PRE_M1 10'h000
`define STC_PRE_M8 10'h007
`define STC_PRE_M64 10'h03F
`define STC_PRE_M256 10'h0FF
`define STC_PRE_M1024 10'h3FF

// capture filter depth in system clocks
`define STC_FILT_DEPTH 4

`endif

// file: src/stc_pkg.sv
package stc_pkg;
   typedef enum logic [1:0] {
      TOP_FIXED,
      TOP_CMP_A,
      TOP_CAP
   } stc_top_src_t;

   typedef enum logic [1:0] {
      SLOPE_NONE,
      SLOPE_FAST,
      SLOPE_PHASE
   } stc_slope_t;

   typedef enum logic {
      DIR_UP,
      DIR_DOWN
   } stc_dir_t;
endpackage

// file: src/stc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module stc_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // levels
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   logic [W-1:0] meta;

   if (W < 1) begin
      $error("stc_sync: W must be at least 1");
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         meta <= '0;
         o_sync <= '0;
      end else begin
         meta <= i_async;
         o_sync <= meta;
      end
   end
endmodule
`default_nettype wire

// file: src/stc_filter.sv
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"
module stc_filter #(
   parameter int DEPTH = `STC_FILT_DEPTH
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // control
   input wire logic i_enable,
   input wire logic i_rising,
   // signal
   input wire logic i_level,
   output logic o_edge
);
   logic [DEPTH-1:0] hist;
   logic level;
   logic prev;
   logic agree_hi;
   logic agree_lo;
   logic next_level;

   if (DEPTH < 2) begin
      $error("stc_filter: DEPTH must be at least 2");
   end

   assign agree_hi = &hist;
   assign agree_lo = ~|hist;
   // output follows the input when disabled, otherwise only moves once every sample agrees
   assign next_level = !i_enable ? i_level :
      agree_hi ? 1'b1 : agree_lo ? 1'b0 : level;

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         hist <= '0;
         level <= 1'b0;
         prev <= 1'b0;
      end else begin
         hist <= {hist[DEPTH-2:0], i_level};
         level <= next_level;
         prev <= level;
      end
   end

   assign o_edge = i_rising ? (level & ~prev) : (~level & prev);
endmodule
`default_nettype wire

// file: dv/stc_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module stc_top_sva #(
   parameter int FILTER_DEPTH = 4
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // apb slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // pins
   input wire logic i_ext_count_pin,
   input wire logic i_capture_pin,
   input wire logic i_comparator_output,
   input wire logic o_compare_out_a,
   input wire logic o_compare_out_b,
   // service requests
   input wire logic [3:0] i_irq_ack,
   input wire logic [3:0] o_irq_req
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire logic acc = i_psel && i_penable;
   wire logic bad = (i_paddr > 8'h30) || (i_paddr[1:0] != 2'h0);
   property p_ready_pulse;
      o_pready |=> !o_pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_one_wait;
      acc && !o_pready |=> o_pready;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready late");
   property p_ready_in_xfer;
      o_pready |-> acc;
   endproperty
   a_ready_in_xfer: assert property (p_ready_in_xfer) else $error("stray pready");
   property p_err_map;
      acc && o_pready |-> (o_pslverr == bad);
   endproperty
   a_err_map: assert property (p_err_map) else $error("pslverr wrong");
   property p_bad_read_zero;
      acc && !o_pready && !i_pwrite && bad |=> o_prdata == 32'h0000_0000;
   endproperty
   a_bad_read_zero: assert property (p_bad_read_zero) else $error("bad read data");
   property p_byte_wide;
      o_prdata[31:8] == 24'h00_0000;
   endproperty
   a_byte_wide: assert property (p_byte_wide) else $error("prdata upper");
   property p_rdata_hold;
      $changed(o_prdata) |-> $past(acc && !i_pwrite && !o_pready);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("prdata moved");
   property p_req_clear;
      |(~o_irq_req & $past(o_irq_req) & ~$past(i_irq_ack))
         |-> $past(acc && i_pwrite && o_pready);
   endproperty
   a_req_clear: assert property (p_req_clear) else $error("req cleared");
endmodule
`default_nettype wire

// file: dv/stc_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module stc_cpu_model (
   // clock
   input wire logic i_clk,
   // apb master
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [7:0] o_paddr,
   output logic [31:0] o_pwdata,
   input wire logic [31:0] i_prdata,
   input wire logic i_pready,
   input wire logic i_pslverr,
   // bench
   output logic o_hang
);
   initial begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'h00;
      o_pwdata = 32'h0000_0000;
      o_hang = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [7:0] d, output logic [31:0] q, output logic e);
      int n;
      @(posedge i_clk);
      o_psel <= 1'b1;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= {24'h00_0000, d};
      @(posedge i_clk);
      o_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (i_pready !== 1'b1 && n < 20);
      if (i_pready !== 1'b1) o_hang <= 1'b1;
      q = i_prdata;
      e = i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // released data lines get the inverse, not a stale copy
      o_pwdata <= ~{24'h00_0000, d};
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      logic e;
      xfer(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] q,
         output logic e);
      xfer(1'b0, a, 8'h00, q, e);
   endtask
   // high byte first on write, low byte first on read
   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a + 8'h04, d[15:8]);
      wr(a, d[7:0]);
   endtask
   task automatic rd16(input logic [7:0] a, output logic [15:0] q);
      logic [31:0] l;
      logic [31:0] h;
      logic e;
      rd(a, l, e);
      rd(a + 8'h04, h, e);
      q = {h[7:0], l[7:0]};
   endtask
endmodule
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"
module tb_top;
   logic i_clk = 1'b0;
   logic i_nrst = 1'b0;
   logic i_ext_count_pin = 1'b0;
   logic i_capture_pin = 1'b0;
   logic i_comparator_output = 1'b0;
   logic [3:0] i_irq_ack = 4'h0;
   logic psel, pen, pwr, pready, perr, oa, ob, hang;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] irq;
   logic [15:0] v;
   logic e;
   int err_count = 0;
   int checks = 0;
   always #5 i_clk = ~i_clk;
   stc_cpu_model u_cpu (.i_clk(i_clk), .o_psel(psel), .o_penable(pen),
      .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata),
      .i_pready(pready), .i_pslverr(perr), .o_hang(hang));
   stc_top #(.FILTER_DEPTH(4)) u_stc_top (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
      .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(perr), .i_ext_count_pin(i_ext_count_pin),
      .i_capture_pin(i_capture_pin),
      .i_comparator_output(i_comparator_output),
      .o_compare_out_a(oa), .o_compare_out_b(ob), .i_irq_ack(i_irq_ack),
      .o_irq_req(irq));
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] x,
         input logic [31:0] g);
      checks++;
      if (g !== x) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] x);
      u_cpu.rd(a, q, e);
      chk($sformatf("reg %h", a), {24'h00_0000, x}, q);
   endtask
   task automatic wait_req(input int b);
      int n;
      for (n = 0; n < 60 && irq[b] !== 1'b1; n++) @(posedge i_clk);
      if (n >= 60) begin
         err_count++;
         give_verdict();
      end
   endtask
   always @(posedge hang) begin
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (4) @(posedge i_clk);
      i_nrst <= 1'b1;
      for (int a = 0; a <= 8'h30; a += 4) rchk(a[7:0], `STC_RST_BYTE);
      u_cpu.wr(`STC_ADDR_CTRL_A, 8'hC3);
      rchk(`STC_ADDR_CTRL_A, 8'hC3);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'h98);
      rchk(`STC_ADDR_CTRL_B, 8'h98);
      u_cpu.wr(`STC_ADDR_CTRL_A, 8'h00);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
      u_cpu.rd(8'h3C, q, e);
      chk("unmapped err", 32'h1, {31'h0, e});
      $display("test registers done");
      u_cpu.wr16(`STC_ADDR_CNT_LO, 16'h1234);
      repeat (20) @(posedge i_clk);
      u_cpu.rd16(`STC_ADDR_CNT_LO, v);
      chk("count held", 32'h1234, {16'h0, v});
      for (int s = 6; s <= 7; s++) begin
         u_cpu.wr16(`STC_ADDR_CNT_LO, 16'h0000);
         u_cpu.wr(`STC_ADDR_CTRL_B, s[7:0]);
         repeat (3) begin
            repeat (4) @(posedge i_clk);
            i_ext_count_pin <= 1'b1;
            repeat (4) @(posedge i_clk);
            i_ext_count_pin <= 1'b0;
         end
         repeat (8) @(posedge i_clk);
         u_cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
         u_cpu.rd16(`STC_ADDR_CNT_LO, v);
         chk("ext count", 32'h3, {16'h0, v});
      end
      $display("test counter done");
      u_cpu.wr(`STC_ADDR_MASK, 8'h01);
      u_cpu.wr16(`STC_ADDR_CNT_LO, 16'hFFFE);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'h01);
      wait_req(`STC_FLAG_OVF);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
      u_cpu.rd(`STC_ADDR_FLAGS, q, e);
      chk("ovf flag", 32'h1, q & 32'h1);
      u_cpu.wr(`STC_ADDR_FLAGS, 8'h0F);
      rchk(`STC_ADDR_FLAGS, 8'h00);
      $display("test overflow done");
      u_cpu.wr(`STC_ADDR_CTRL_A, 8'h10);
      u_cpu.wr16(`STC_ADDR_CNT_LO, 16'h0010);
      u_cpu.wr16(`STC_ADDR_CMPA_LO, 16'h0012);
      u_cpu.wr16(`STC_ADDR_CMPB_LO, 16'h0014);
      u_cpu.wr(`STC_ADDR_MASK, 8'h06);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'h01);
      wait_req(`STC_FLAG_MB);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'h00);
      rchk(`STC_ADDR_FLAGS, 8'h06);
      chk("out b", 32'h1, {31'h0, ob});
      chk("out a", 32'h0, {31'h0, oa});
      i_irq_ack <= 4'h2;
      @(posedge i_clk);
      i_irq_ack <= 4'h0;
      repeat (2) @(posedge i_clk);
      chk("req after ack", 32'h4, {28'h0, irq});
      u_cpu.wr(`STC_ADDR_FLAGS, 8'h04);
      rchk(`STC_ADDR_FLAGS, 8'h00);
      $display("test compare done");
      u_cpu.wr16(`STC_ADDR_CNT_LO, 16'h0ABC);
      u_cpu.wr(`STC_ADDR_MASK, 8'h08);
      u_cpu.wr(`STC_ADDR_CTRL_B, 8'hC0);
      i_capture_pin <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_capture_pin <= 1'b0;
      repeat (20) @(posedge i_clk);
      chk("glitch req", 32'h0, {28'h0, irq});
      i_capture_pin <= 1'b1;
      wait_req(`STC_FLAG_CAP);
      u_cpu.rd16(`STC_ADDR_CAP_LO, v);
      chk("capture", 32'h0ABC, {16'h0, v});
      u_cpu.wr(`STC_ADDR_FLAGS, 8'h08);
      u_cpu.wr16(`STC_ADDR_CNT_LO, 16'h0456);
      u_cpu.wr(`STC_ADDR_AUX, 8'h01);
      // let the filter settle low on the new source first
      repeat (8) @(posedge i_clk);
      i_comparator_output <= 1'b1;
      wait_req(`STC_FLAG_CAP);
      u_cpu.rd16(`STC_ADDR_CAP_LO, v);
      chk("comparator capture", 32'h0456, {16'h0, v});
      $display("test capture done");
      give_verdict();
   end
endmodule
bind stc_top stc_top_sva #(.FILTER_DEPTH(FILTER_DEPTH)) u_stc_top_sva (
   .i_clk(i_clk), .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
   .i_ext_count_pin(i_ext_count_pin), .i_capture_pin(i_capture_pin),
   .i_comparator_output(i_comparator_output),
   .o_compare_out_a(o_compare_out_a), .o_compare_out_b(o_compare_out_b),
   .i_irq_ack(i_irq_ack), .o_irq_req(o_irq_req));
`default_nettype wire
